/* File: src/oscsys_top.sv */
// internal oscillator control, system clock divide and select, suspend and wake
// assumes a 200 MHz free-running i_clk standing in for the oscillator reference,
// a byte-wide special-register port, and raw pins on the port and oscillator inputs
`timescale 1ns/1ps
`include "oscsys_defs.svh"

// Notes on behaviour
// - reset selects internal oscillator as source
// - divide code 0..7 gives 128 down to 1
// - enable field 11 runs, 00 stops oscillator
// - suspend bit stops oscillator and internal clock
// - wake on port0, port1 match or comparator low
// - wake restarts oscillator regardless of interrupt
// - processor resumes after the suspending write
// - ready flag shows oscillator at programmed frequency
// - unused bits read zero, ignore writes
// - coarse trim seven bits, factory reset value
// - fine trim six bits, software writes 0..0x27
// - port1 match when masked pins differ
// - mask zero excludes pin, one compares it
// - system clock from internal or external source
// - crystal claims two pins, other enabled modes one, off modes none
// - external mode field decodes eight codes into six modes: 000 and 001 both off, 100 and 101 alike
module oscsys_top #(
  parameter logic [6:0] COARSE_RESET = `OSCSYS_RST_COARSE_TRIM,
  parameter logic [5:0] FINE_RESET   = `OSCSYS_RST_FINE_TRIM,
  parameter int         SETTLE_CYC   = `OSCSYS_SETTLE_CYC
) (
  input  logic                         i_clk,
  input  logic                         i_rst_b,
  input  oscsys_pkg::oscsys_sfr_req_t  i_sfr,
  output logic [7:0]                   o_sfr_rdata,
  input  logic [7:0]                   i_port1_pins,
  input  logic                         i_port0_match,
  input  logic                         i_cmp_enable,
  input  logic                         i_cmp_out,
  input  logic                         i_ext_osc_clk,
  input  logic                         i_crystal_ok,
  input  logic                         i_system_clock_src_ext,
  output logic                         o_system_clock,
  output logic                         o_system_clock_is_ext,
  output logic                         o_cpu_halt,
  output logic                         o_internal_osc_run,
  output logic                         o_internal_osc_ready,
  output logic [6:0]                   o_coarse_trim,
  output logic [5:0]                   o_fine_trim,
  output logic [2:0]                   o_ext_mode,
  output logic [2:0]                   o_ext_freq_range,
  output logic                         o_ext_in_pin_claim,
  output logic                         o_ext_out_pin_claim,
  output logic                         o_wake_request,
  output logic                         o_port1_match_event
);

  initial begin
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) $error("SETTLE_CYC out of range");
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  function automatic logic hit(input oscsys_pkg::oscsys_sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  wire wr_ctrl_w   = hit(i_sfr, `OSCSYS_ADDR_CTRL);
  wire wr_coarse_w = hit(i_sfr, `OSCSYS_ADDR_COARSE_TRIM);
  wire wr_fine_w   = hit(i_sfr, `OSCSYS_ADDR_FINE_TRIM);
  wire wr_mask_w   = hit(i_sfr, `OSCSYS_ADDR_P1_MASK);
  wire wr_value_w  = hit(i_sfr, `OSCSYS_ADDR_P1_VALUE);
  wire wr_ext_w    = hit(i_sfr, `OSCSYS_ADDR_EXT_CTRL);

  logic [1:0] en_q;
  logic       suspend_q;
  logic [2:0] div_q;
  logic [6:0] coarse_q;
  logic [5:0] fine_q;
  logic [7:0] mask_q;
  logic [7:0] value_q;
  logic [2:0] xmode_q;
  logic [2:0] xfreq_q;
  logic [7:0] rdata_q;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] p1_m_q, p1_s_q;
  logic [2:0] pin_m_q, pin_s_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      p1_m_q  <= 8'hff;
      p1_s_q  <= 8'hff;
      pin_m_q <= 3'h1;
      pin_s_q <= 3'h1;
    end else begin
      p1_m_q  <= i_port1_pins;
      p1_s_q  <= p1_m_q;
      pin_m_q <= {i_crystal_ok, i_ext_osc_clk, i_cmp_out};
      pin_s_q <= pin_m_q;
    end
  end

  wire cmp_s_w   = pin_s_q[0];
  wire extclk_w  = pin_s_q[1];
  wire xvalid_w  = pin_s_q[2];

  // ------------------------------------------------------------
  // match and wake
  // ------------------------------------------------------------
  // raw-pin path: a suspended clock cannot be relied on to sample anything
  assign o_wake_request = (|((i_port1_pins ^ value_q) & mask_q)) || i_port0_match
                          || (i_cmp_enable && !i_cmp_out);
  wire p1_match_w = |((p1_s_q ^ value_q) & mask_q);
  wire cmp_wake_w = i_cmp_enable && !cmp_s_w;
  wire wake_w     = p1_match_w || i_port0_match || cmp_wake_w;
  assign o_port1_match_event = p1_match_w;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      en_q     <= 2'(`OSCSYS_RST_CTRL >> `OSCSYS_CTRL_EN_LO);
      div_q    <= 3'h0;
      coarse_q <= COARSE_RESET;
      fine_q   <= FINE_RESET;
      mask_q   <= `OSCSYS_RST_P1_MASK;
      value_q  <= `OSCSYS_RST_P1_VALUE;
      xmode_q  <= 3'h0;
      xfreq_q  <= 3'h0;
    end else begin
      if (wr_ctrl_w) begin
        en_q  <= i_sfr.wdata[`OSCSYS_CTRL_EN_HI:`OSCSYS_CTRL_EN_LO];
        div_q <= i_sfr.wdata[`OSCSYS_CTRL_DIV_HI:0];
      end
      if (wr_coarse_w) coarse_q <= i_sfr.wdata[6:0];
      if (wr_fine_w) fine_q <= i_sfr.wdata[5:0];
      if (wr_mask_w) mask_q <= i_sfr.wdata;
      if (wr_value_w) value_q <= i_sfr.wdata;
      if (wr_ext_w) begin
        xmode_q <= i_sfr.wdata[`OSCSYS_EXT_MODE_HI:`OSCSYS_EXT_MODE_LO];
        xfreq_q <= i_sfr.wdata[`OSCSYS_EXT_FREQ_HI:0];
      end
    end
  end

  // wake clears, and beats a suspend write in the same cycle
  wire suspend_d = wake_w ? 1'b0 :
                   (wr_ctrl_w && i_sfr.wdata[`OSCSYS_CTRL_SUSPEND]) ? 1'b1 : suspend_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) suspend_q <= 1'b0;
    else suspend_q <= suspend_d;
  end

  // ------------------------------------------------------------
  // internal oscillator run and ready
  // ------------------------------------------------------------
  // 01 and the undefined 10 both leave the oscillator off
  wire osc_run_w = (en_q == `OSCSYS_EN_RUN) && !suspend_q;
  logic [15:0] settle_q;
  logic        ready_q;

  // any trim write detunes the oscillator, so ready restarts
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !osc_run_w || wr_coarse_w || wr_fine_w) begin
      settle_q <= 16'h0000;
      ready_q  <= 1'b0;
    end else if (settle_q == 16'(SETTLE_CYC - 1)) begin
      ready_q  <= 1'b1;
    end else begin
      settle_q <= settle_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // external oscillator decode
  // ------------------------------------------------------------
  wire x_on_w      = xmode_q[2] | xmode_q[1];
  wire x_crystal_w = xmode_q[2:1] == 2'h3;
  wire x_halve_w   = xmode_q[0] && (xmode_q[2:1] == 2'h1 || x_crystal_w);
  logic ext_prev_q, ext_half_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ext_prev_q <= 1'b0;
      ext_half_q <= 1'b0;
    end else begin
      ext_prev_q <= extclk_w;
      if (extclk_w && !ext_prev_q) ext_half_q <= ~ext_half_q;
    end
  end

  wire ext_lvl_w = !x_on_w ? 1'b0 : x_halve_w ? ext_half_q : extclk_w;
  assign o_ext_in_pin_claim  = x_crystal_w;
  assign o_ext_out_pin_claim = x_on_w;

  // ------------------------------------------------------------
  // clock path
  // ------------------------------------------------------------
  logic int_lvl_w, sel_ext_w;

  oscsys_clk_div u_div (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_run      (osc_run_w),
    .i_div_code (div_q),
    .o_clk_lvl  (int_lvl_w)
  );

  oscsys_clk_mux u_mux (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_int_lvl (int_lvl_w),
    .i_ext_lvl (ext_lvl_w),
    .i_sel_ext (i_system_clock_src_ext),
    .o_clk     (o_system_clock),
    .o_sel_ext (sel_ext_w)
  );

  // processor holds its next fetch, so it resumes after the suspending write
  assign o_cpu_halt = suspend_q && !sel_ext_w;

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  wire [7:0] rd_ctrl_w = {en_q, suspend_q, ready_q, 1'b0, div_q};
  wire [7:0] rd_ext_w  = {xvalid_w && x_crystal_w, xmode_q, 1'b0, xfreq_q};

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) rdata_q <= 8'h00;
    else if (i_sfr.rd) begin
      unique case (i_sfr.addr)
        `OSCSYS_ADDR_CTRL:        rdata_q <= rd_ctrl_w;
        `OSCSYS_ADDR_COARSE_TRIM: rdata_q <= {1'b0, coarse_q};
        `OSCSYS_ADDR_FINE_TRIM:   rdata_q <= {2'h0, fine_q};
        `OSCSYS_ADDR_P1_MASK:     rdata_q <= mask_q;
        `OSCSYS_ADDR_P1_VALUE:    rdata_q <= value_q;
        `OSCSYS_ADDR_EXT_CTRL:    rdata_q <= rd_ext_w;
        default:                  rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_sfr_rdata          = rdata_q;
  assign o_system_clock_is_ext      = sel_ext_w;
  assign o_internal_osc_run   = osc_run_w;
  assign o_internal_osc_ready = ready_q;
  assign o_coarse_trim        = coarse_q;
  assign o_fine_trim          = fine_q;
  assign o_ext_mode           = xmode_q;
  assign o_ext_freq_range     = xfreq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_suspend_write;
    wr_ctrl_w && i_sfr.wdata[`OSCSYS_CTRL_SUSPEND] && !wake_w;
  endsequence

  sequence s_wake;
    suspend_q && wake_w;
  endsequence

  chk_suspend_stops_osc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_suspend_write |=> suspend_q && !o_internal_osc_run)
    else $error("suspend did not stop oscillator");

  chk_wake_restarts: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_wake |=> !suspend_q ##0 (o_internal_osc_run == (en_q == `OSCSYS_EN_RUN)))
    else $error("wake did not restart oscillator");

  chk_wake_sources: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(suspend_q) |-> $past(p1_match_w || i_port0_match || cmp_wake_w))
    else $error("suspend left without a wake source");

  chk_halt_internal: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_suspend_write ##1 !o_system_clock_is_ext |-> o_cpu_halt)
    else $error("processor not halted after suspend write");

  chk_reset_source: assert property (@(posedge i_clk)
    !i_rst_b |=> !o_system_clock_is_ext && en_q == `OSCSYS_EN_RUN && div_q == 3'h0)
    else $error("reset left wrong clock setup");

  chk_ready_settles: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(ready_q) |-> $past(osc_run_w) && $past(settle_q) == 16'(SETTLE_CYC - 1)
      && !$past(wr_coarse_w || wr_fine_w))
    else $error("ready rose before settling");

  chk_ready_drops: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !osc_run_w |=> !ready_q)
    else $error("ready held with oscillator off");

  chk_mask_excludes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (mask_q == 8'h00) |-> !p1_match_w)
    else $error("masked pins raised a match");

  chk_ctrl_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_sfr.rd && i_sfr.addr == `OSCSYS_ADDR_CTRL) |=> o_sfr_rdata[3] == 1'b0
      && o_sfr_rdata[`OSCSYS_CTRL_READY] == $past(ready_q))
    else $error("control read shows wrong bits");

  chk_pin_claim: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_ext_in_pin_claim |-> o_ext_out_pin_claim && xmode_q[2:1] == 2'h3)
    else $error("input pin claimed outside crystal mode");

endmodule

/* File: src/oscsys_defs.svh */
// register map, field positions, reset values and timing counts of the clock block
// assumes the includer also sees oscsys_pkg for the types
`ifndef OSCSYS_DEFS_SVH
`define OSCSYS_DEFS_SVH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define OSCSYS_ADDR_FINE_TRIM   8'hb0
`define OSCSYS_ADDR_EXT_CTRL    8'hb1
`define OSCSYS_ADDR_CTRL        8'hb2
`define OSCSYS_ADDR_COARSE_TRIM 8'hb3
`define OSCSYS_ADDR_P1_MASK     8'hbf
`define OSCSYS_ADDR_P1_VALUE    8'hcf

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define OSCSYS_RST_CTRL         8'hc0
`define OSCSYS_RST_P1_MASK      8'h00
`define OSCSYS_RST_P1_VALUE     8'hff
`define OSCSYS_RST_EXT_CTRL     8'h00
`define OSCSYS_RST_COARSE_TRIM  7'h40
`define OSCSYS_RST_FINE_TRIM    6'h14

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define OSCSYS_CTRL_EN_HI       7
`define OSCSYS_CTRL_EN_LO       6
`define OSCSYS_CTRL_SUSPEND     5
`define OSCSYS_CTRL_READY       4
`define OSCSYS_CTRL_DIV_HI      2
`define OSCSYS_EXT_VALID        7
`define OSCSYS_EXT_MODE_HI      6
`define OSCSYS_EXT_MODE_LO      4
`define OSCSYS_EXT_FREQ_HI      2
`define OSCSYS_EN_RUN           2'h3
`define OSCSYS_DIV_MAX_HALF     8'h80

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OSCSYS_CLK_MHZ          200
`define OSCSYS_SETTLE_NS        1000
`define OSCSYS_SETTLE_CYC       ((`OSCSYS_SETTLE_NS * `OSCSYS_CLK_MHZ + 999) / 1000)

`endif

/* File: src/oscsys_pkg.sv */
// types shared by the clock block modules
// assumes nothing beyond a SystemVerilog compiler
package oscsys_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } oscsys_sfr_req_t;

  typedef enum logic [1:0] {
    MUX_RUN,
    MUX_WAIT_OLD_LOW,
    MUX_WAIT_NEW_LOW
  } oscsys_mux_state_t;

endpackage

/* File: src/oscsys_clk_div.sv */
// post-divider of the internal oscillator, modelled as a 100 MHz toggle of i_clk
// assumes i_div_code comes from logic on i_clk
`timescale 1ns/1ps
`include "oscsys_defs.svh"

module oscsys_clk_div (
  input  logic       i_clk,
  input  logic       i_rst_b,
  input  logic       i_run,
  input  logic [2:0] i_div_code,
  output logic       o_clk_lvl
);

  logic [7:0] cnt_q;
  logic       lvl_q;
  wire  [7:0] half_w = `OSCSYS_DIV_MAX_HALF >> i_div_code;

  // ------------------------------------------------------------
  // phase counter
  // ------------------------------------------------------------
  // ratio sampled only at a phase boundary, so no runt phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (i_run && cnt_q == 8'h00) begin
      lvl_q <= ~lvl_q;
      cnt_q <= half_w - 8'h01;
    end else if (i_run) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign o_clk_lvl = lvl_q;

  chk_div_phase_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (cnt_q != 8'h00) |=> $stable(lvl_q))
    else $error("divider phase cut short");

  chk_div_stop_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_run |=> $stable(lvl_q))
    else $error("divider moved while stopped");

endmodule

/* File: src/oscsys_clk_mux.sv */
// glitch-free two-way clock level switch
// assumes both inputs are levels sampled on i_clk; an absent new clock held high stalls the switch, one held low does not
`timescale 1ns/1ps

module oscsys_clk_mux (
  input  logic i_clk,
  input  logic i_rst_b,
  input  logic i_int_lvl,
  input  logic i_ext_lvl,
  input  logic i_sel_ext,
  output logic o_clk,
  output logic o_sel_ext
);

  oscsys_pkg::oscsys_mux_state_t state_q;
  oscsys_pkg::oscsys_mux_state_t state_d;
  logic cur_q;
  logic clk_q;

  wire cur_lvl_w = cur_q ? i_ext_lvl : i_int_lvl;
  wire new_lvl_w = cur_q ? i_int_lvl : i_ext_lvl;
  wire park_w    = (state_d == oscsys_pkg::MUX_WAIT_NEW_LOW) || (state_q == oscsys_pkg::MUX_WAIT_NEW_LOW);

  // ------------------------------------------------------------
  // switch sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      oscsys_pkg::MUX_RUN: begin
        if (i_sel_ext != cur_q) state_d = oscsys_pkg::MUX_WAIT_OLD_LOW;
      end
      oscsys_pkg::MUX_WAIT_OLD_LOW: begin
        if (!cur_lvl_w) state_d = oscsys_pkg::MUX_WAIT_NEW_LOW;
      end
      oscsys_pkg::MUX_WAIT_NEW_LOW: begin
        if (!new_lvl_w) state_d = oscsys_pkg::MUX_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= oscsys_pkg::MUX_RUN;
      cur_q   <= 1'b0;
      clk_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == oscsys_pkg::MUX_WAIT_NEW_LOW && !new_lvl_w) cur_q <= ~cur_q;
      // output parked low across the handover, switch edge included: the old level may be high again there
      clk_q <= park_w ? 1'b0 : cur_lvl_w;
    end
  end

  assign o_clk     = clk_q;
  assign o_sel_ext = cur_q;

  chk_mux_switch_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $changed(cur_q) |-> !clk_q)
    else $error("clock source switched while high");

endmodule

/* File: bench/oscsys_top_bench.sv */
// self-checking bench for the clock block top: registers, divide, suspend and wake, source switch
// assumes the design sources and oscsys_defs.svh are compiled before this file
`timescale 1ns/1ps
`include "oscsys_defs.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end

module oscsys_top_bench;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} oscsys_tb_row_t;

  logic                        i_clk;
  logic                        i_rst_b;
  oscsys_pkg::oscsys_sfr_req_t sfr;
  logic [7:0]                  rdata;
  logic [7:0]                  pins;
  logic [7:0]                  rd;
  logic                        p0m, cmp_en, cmp_out, xtal_ok, src_ext;
  logic                        ext_clk = 1'b0;
  logic [1:0]                  ext_div = 2'h0;
  logic                        sys_clk, is_ext, halt, osc_run, osc_rdy;
  logic                        in_claim, out_claim, wake, p1_evt;
  logic [6:0]                  coarse;
  logic [5:0]                  fine;
  logic [2:0]                  xmode, xfreq;
  int                          err_total, num_checks, len;
  logic [7:0]                  pin_vec[4] = '{8'h05, 8'hf5, 8'h04, 8'h0d};
  logic                        evt_vec[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  oscsys_tb_row_t              rows[8] = '{
    '{8'hb3, 8'hff, 8'hff, 8'h7f},
    '{8'hb0, 8'he5, 8'hff, 8'h25},
    '{8'hb0, 8'h27, 8'hff, 8'h27},
    '{8'hb2, 8'hcd, 8'hef, 8'hc5},
    '{8'hbf, 8'ha5, 8'hff, 8'ha5},
    '{8'hcf, 8'h3c, 8'hff, 8'h3c},
    '{8'hb1, 8'h7f, 8'hff, 8'h77},
    '{8'h5a, 8'hff, 8'hff, 8'h00}};

  oscsys_top #(.COARSE_RESET(7'h2a), .FINE_RESET(6'h11), .SETTLE_CYC(4)) i_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_port1_pins(pins), .i_port0_match(p0m), .i_cmp_enable(cmp_en), .i_cmp_out(cmp_out),
    .i_ext_osc_clk(ext_clk), .i_crystal_ok(xtal_ok), .i_system_clock_src_ext(src_ext),
    .o_system_clock(sys_clk), .o_system_clock_is_ext(is_ext), .o_cpu_halt(halt),
    .o_internal_osc_run(osc_run), .o_internal_osc_ready(osc_rdy), .o_coarse_trim(coarse),
    .o_fine_trim(fine), .o_ext_mode(xmode), .o_ext_freq_range(xfreq),
    .o_ext_in_pin_claim(in_claim), .o_ext_out_pin_claim(out_claim),
    .o_wake_request(wake), .o_port1_match_event(p1_evt));

  // ------------------------------------------------------------
  // clocks and helpers
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // free-running 25 MHz external clock, slow enough for the pin synchroniser
  always @(posedge i_clk) begin
    ext_div <= ext_div + 2'h1;
    if (ext_div == 2'h3) ext_clk <= ~ext_clk;
  end

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge i_clk);
    sfr.wr <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge i_clk);
    sfr.rd <= 1'b0;
    tick();
    d = rdata;
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    while (osc_rdy !== 1'b1 && k < 60) begin tick(); k++; end
  endtask

  // length of one full high phase of the system clock, seen from a low phase
  task automatic hi_len(output int n);
    int k;
    n = 0;
    k = 0;
    while (sys_clk !== 1'b0 && k < 600) begin tick(); k++; end
    while (sys_clk !== 1'b1 && k < 600) begin tick(); k++; end
    while (sys_clk === 1'b1 && k < 600) begin tick(); n++; k++; end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_clk);
    err_total++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0; sfr = '0; pins = 8'h3a; p0m = 1'b0; cmp_en = 1'b0;
    cmp_out = 1'b0; xtal_ok = 1'b0; src_ext = 1'b0;
    err_total = 0; num_checks = 0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    tick();
    `CHK("src_rst", 1'b0, is_ext);
    sfr_rd(8'hb2, rd); `CHK("ctrl_rst", 8'hc0, rd & 8'hef);
    sfr_rd(8'hb3, rd); `CHK("coarse_rst", 8'h2a, rd);
    sfr_rd(8'hb0, rd); `CHK("fine_rst", 8'h11, rd);
    sfr_rd(8'hbf, rd); `CHK("mask_rst", 8'h00, rd);
    sfr_rd(8'hcf, rd); `CHK("value_rst", 8'hff, rd);
    `CHK("match_masked", 1'b0, p1_evt);
    for (int i = 0; i < 8; i++) begin
      sfr_wr(rows[i].a, rows[i].d);
      sfr_rd(rows[i].a, rd);
      `CHK("reg_row", rows[i].e, rd & rows[i].m);
    end
    `CHK("coarse_out", 7'h7f, coarse);
    `CHK("fine_out", 6'h27, fine);
    // divide ratios, the second high phase after a change shows the new ratio
    for (int c = 0; c < 8; c++) begin
      sfr_wr(8'hb2, {5'h18, c[2:0]});
      hi_len(len);
      hi_len(len);
      `CHK("div_phase", 128 >> c, len);
    end
    // external mode decode and pin claims
    for (int m = 0; m < 8; m++) begin
      sfr_wr(8'hb1, {1'b0, m[2:0], 1'b0, m[2:0]});
      tick();
      `CHK("ext_mode", m[2:0], xmode);
      `CHK("ext_freq", m[2:0], xfreq);
      `CHK("in_claim", m[2:1] == 2'b11, in_claim);
      `CHK("out_claim", m[2:1] != 2'b00, out_claim);
    end
    @(posedge i_clk);
    xtal_ok <= 1'b1;
    sfr_wr(8'hb1, 8'h60); repeat (4) tick();
    sfr_rd(8'hb1, rd); `CHK("xtal_valid", 8'he0, rd);
    sfr_wr(8'hb1, 8'h40); repeat (4) tick();
    sfr_rd(8'hb1, rd); `CHK("valid_hidden", 8'h40, rd);
    // port-1 match with half the pins masked out
    sfr_wr(8'hbf, 8'h0f);
    sfr_wr(8'hcf, 8'h05);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      pins <= pin_vec[i];
      repeat (5) tick();
      `CHK("p1_match", evt_vec[i], p1_evt);
      `CHK("p1_wake", evt_vec[i], wake);
    end
    @(posedge i_clk);
    pins <= 8'h05;
    repeat (3) tick();
    wait_rdy();
    // suspend then wake from each source; comparator output is low but disabled
    for (int s = 0; s < 3; s++) begin
      sfr_wr(8'hb2, 8'he7);
      tick();
      `CHK("halt_on", 1'b1, halt);
      `CHK("osc_stop", 1'b0, osc_run);
      repeat (4) tick();
      `CHK("halt_held", 1'b1, halt);
      `CHK("rdy_stop", 1'b0, osc_rdy);
      @(posedge i_clk);
      if (s == 0) p0m <= 1'b1;
      else if (s == 1) cmp_en <= 1'b1;
      else pins <= 8'h04;
      tick();
      `CHK("wake_now", 1'b1, wake);
      repeat (6) tick();
      `CHK("halt_off", 1'b0, halt);
      `CHK("osc_back", 1'b1, osc_run);
      @(posedge i_clk);
      p0m <= 1'b0;
      cmp_en <= 1'b0;
      pins <= 8'h05;
      wait_rdy();
      `CHK("rdy_back", 1'b1, osc_rdy);
    end
    // a suspend write during an active wake is dropped
    @(posedge i_clk);
    p0m <= 1'b1;
    sfr_wr(8'hb2, 8'he7);
    repeat (2) tick();
    `CHK("wake_wins", 1'b0, halt);
    @(posedge i_clk);
    p0m <= 1'b0;
    // enable field off and reserved
    sfr_wr(8'hb2, 8'h07); repeat (3) tick();
    `CHK("en_off", 1'b0, osc_run);
    `CHK("rdy_off", 1'b0, osc_rdy);
    sfr_wr(8'hb2, 8'h47); tick();
    `CHK("en_rsvd", 1'b0, osc_run);
    sfr_wr(8'hb2, 8'hc7); wait_rdy();
    `CHK("en_run", 1'b1, osc_rdy);
    // switch to the external source, suspend there, then reset mid-run
    @(posedge i_clk);
    src_ext <= 1'b1;
    for (int k = 0; k < 1000 && is_ext !== 1'b1; k++) tick();
    `CHK("to_ext", 1'b1, is_ext);
    sfr_wr(8'hb2, 8'he7); tick();
    `CHK("ext_no_halt", 1'b0, halt);
    `CHK("ext_osc_stop", 1'b0, osc_run);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    src_ext <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    tick();
    `CHK("src_rst2", 1'b0, is_ext);
    sfr_rd(8'hb2, rd); `CHK("ctrl_rst2", 8'hc0, rd & 8'hef);
    sfr_rd(8'hbf, rd); `CHK("mask_rst2", 8'h00, rd);
    give_verdict();
  end
endmodule
